// ### verilog/port_io_pkg.sv
// package of constants for the three-port i/o block with keypad wake
// assumes a single 10 MHz cpu clock domain and a plain register port
package port_io_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [3:0] ADDR_PORT0       = 4'h0;
  localparam logic [3:0] ADDR_PORT1       = 4'h1;
  localparam logic [3:0] ADDR_PORT2       = 4'h2;
  localparam logic [3:0] ADDR_MODE_A0     = 4'h3;
  localparam logic [3:0] ADDR_MODE_B0     = 4'h4;
  localparam logic [3:0] ADDR_MODE_A1     = 4'h5;
  localparam logic [3:0] ADDR_MODE_B1     = 4'h6;
  localparam logic [3:0] ADDR_MODE_A2     = 4'h7;
  localparam logic [3:0] ADDR_MODE_B2     = 4'h8;
  localparam logic [3:0] ADDR_KEYPAD_EN   = 4'h9;
  localparam logic [3:0] ADDR_AUX_ONE     = 4'hA;
  localparam logic [3:0] ADDR_INT_ENABLE  = 4'hB;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // port_two_mode_reg_a: bits 1:0 are the oscillator-shared pin modes
  localparam int P2A_SCHMITT0_BIT = 2;
  localparam int P2A_SCHMITT1_BIT = 3;
  localparam int P2A_SCHMITT2_BIT = 4;
  localparam int P2A_TOGGLE0_BIT  = 5;
  localparam int P2A_TOGGLE1_BIT  = 6;
  localparam int P2A_CLKOUT_BIT   = 7;
  localparam int AUX_KBF_BIT      = 1;
  localparam int IEN_GLOBAL_BIT   = 0;
  localparam int IEN_KEYPAD_BIT   = 1;
  // pin indices on port 1 and port 2
  localparam int FIXED_OD_A_IDX   = 2;
  localparam int FIXED_OD_B_IDX   = 3;
  localparam int RESET_PIN_IDX    = 5;
  localparam int OSC_OUT_IDX      = 0;
  localparam int OSC_IN_IDX       = 1;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] LATCH_RST_HIGH = 8'hFF;
  localparam logic [7:0] LATCH_RST_LOW  = 8'h00;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         CLK_HZ         = 10_000_000;
  localparam int         STRONG_CPU_CLKS = 2;
  localparam int         STRONG_CYCLES  = (STRONG_CPU_CLKS < 1) ? 1 : STRONG_CPU_CLKS;

  typedef enum logic [1:0] {
    MODE_QUASI = 2'b00,
    MODE_PUSH  = 2'b01,
    MODE_INPUT = 2'b10,
    MODE_OPEN  = 2'b11
  } pin_mode_e;

endpackage

// ### verilog/port_pin_cell.sv
// one pin output structure: pull-ups and pull-down; the pin level gates the weak pull-up
// assumes pin_level_in is already synchronised to sys_clk_in
`timescale 1ns/1ps
module port_pin_cell (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       latch_in,
  input  wire logic       pin_level_in,
  input  wire logic       disable_in,
  output logic            very_weak_up_out,
  output logic            weak_up_out,
  output logic            strong_up_out,
  output logic            pull_down_out
);

  logic       latch_d;
  logic [1:0] strong_cnt;
  logic       rise;

  assign rise = latch_in && !latch_d;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_d <= 1'b0;
    end else begin
      latch_d <= latch_in;
    end
  end

  // strong pull-up burst after a 0 to 1 latch change
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strong_cnt <= 2'd0;
    end else if (rise && mode_in == port_io_pkg::MODE_QUASI && !disable_in) begin
      // the rise cycle itself is the first clock of the burst, so count one less
      strong_cnt <= 2'(port_io_pkg::STRONG_CYCLES - 1);
    end else if (strong_cnt != 2'd0) begin
      strong_cnt <= strong_cnt - 2'd1;
    end
  end

  always_comb begin
    very_weak_up_out = 1'b0;
    weak_up_out      = 1'b0;
    strong_up_out    = 1'b0;
    pull_down_out    = 1'b0;
    if (!disable_in) begin
      case (mode_in)
        port_io_pkg::MODE_QUASI: begin
          very_weak_up_out = latch_in;
          weak_up_out      = latch_in && pin_level_in;
          // a latch that falls mid-burst drops the strong pull-up at once
          strong_up_out    = latch_in && (rise || strong_cnt != 2'd0);
          pull_down_out    = !latch_in;
        end
        port_io_pkg::MODE_PUSH: begin
          strong_up_out = latch_in;
          pull_down_out = !latch_in;
        end
        port_io_pkg::MODE_OPEN: begin
          pull_down_out = !latch_in;
        end
        default: begin
          // input only: every driver off
        end
      endcase
    end
  end

endmodule

// ### verilog/port_io_keypad.sv
// three 8-bit i/o ports with per-pin output modes and keypad wake on port 0
// assumes pins arrive asynchronously; configuration straps are static levels
`timescale 1ns/1ps
module port_io_keypad (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [7:0]  reg_rdata_out,
  // configuration straps
  input  wire logic        pin_reset_high_select_in,
  input  wire logic        internal_reset_in,
  input  wire logic        crystal_osc_in,
  // pins
  input  wire logic [23:0] pin_level_in,
  output logic      [23:0] very_weak_up_out,
  output logic      [23:0] weak_up_out,
  output logic      [23:0] strong_up_out,
  output logic      [23:0] pull_down_out,
  output logic      [2:0]  schmitt_select_out,
  output logic             reset_pin_schmitt_out,
  output logic             fixed_pins_schmitt_out,
  output logic      [1:0]  timer_toggle_enable_out,
  output logic             clock_out_enable_out,
  // cpu side
  output logic             keypad_int_request_out,
  output logic             keypad_wake_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // a register write lands only when the strobe and the address agree
  function automatic logic write_hit(input logic       strobe,
                                     input logic [3:0] addr,
                                     input logic [3:0] target);
    return strobe && (addr == target);
  endfunction

  // flat pin index to port number; port 0 holds pins 7:0
  function automatic int port_of(input int pin);
    return pin / 8;
  endfunction

  // flat pin index to bit position inside its port
  function automatic int bit_of(input int pin);
    return pin % 8;
  endfunction

  // input path of one port; a disabled pin reads as 0 so a floating
  // oscillator or reset pin never leaks noise into software
  function automatic logic [7:0] port_view(input logic [7:0] level,
                                           input logic [7:0] off);
    return level & ~off;
  endfunction

  // ****************************************************************
  // pin synchroniser and configuration capture
  // ****************************************************************
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;
  logic        reset_seen;
  logic        reset_high;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta <= 24'h00_0000;
      pin_sync <= 24'h00_0000;
    end else begin
      pin_meta <= pin_level_in;
      pin_sync <= pin_meta;
    end
  end

  // the strap is caught on the first edge after release, never by the reset itself
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_seen <= 1'b0;
      reset_high <= 1'b0;
    end else if (!reset_seen) begin
      reset_seen <= 1'b1;
      reset_high <= pin_reset_high_select_in;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] port_latch [3];
  logic [7:0] port_mode_select_a [3];
  logic [7:0] port_mode_select_b [3];
  logic [7:0] keypad_pin_enable_reg;
  logic       keypad_wake_flag;
  logic       keypad_int_enable;
  logic       global_int_enable;
  logic       keypad_low;
  logic [23:0] cell_disable;
  logic [1:0]  cell_mode [24];

  // latches follow the strap on the first clock, then software writes
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < 3; p++) begin
        port_latch[p] <= port_io_pkg::LATCH_RST_LOW;
      end
    end else if (!reset_seen) begin
      for (int p = 0; p < 3; p++) begin
        port_latch[p] <= pin_reset_high_select_in ? port_io_pkg::LATCH_RST_HIGH
                                                  : port_io_pkg::LATCH_RST_LOW;
      end
    end else if (reg_write_in && reg_addr_in <= port_io_pkg::ADDR_PORT2) begin
      port_latch[reg_addr_in[1:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < 3; p++) begin
        port_mode_select_a[p] <= port_io_pkg::MODE_RESET;
        port_mode_select_b[p] <= port_io_pkg::MODE_RESET;
      end
    end else if (reg_write_in) begin
      case (reg_addr_in)
        port_io_pkg::ADDR_MODE_A0: port_mode_select_a[0] <= reg_wdata_in;
        port_io_pkg::ADDR_MODE_B0: port_mode_select_b[0] <= reg_wdata_in;
        port_io_pkg::ADDR_MODE_A1: port_mode_select_a[1] <= reg_wdata_in;
        port_io_pkg::ADDR_MODE_B1: port_mode_select_b[1] <= reg_wdata_in;
        port_io_pkg::ADDR_MODE_A2: port_mode_select_a[2] <= reg_wdata_in;
        port_io_pkg::ADDR_MODE_B2: port_mode_select_b[2] <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      keypad_pin_enable_reg <= port_io_pkg::REG_RESET;
      keypad_int_enable     <= 1'b0;
      global_int_enable     <= 1'b0;
    end else begin
      if (write_hit(reg_write_in, reg_addr_in, port_io_pkg::ADDR_KEYPAD_EN)) begin
        keypad_pin_enable_reg <= reg_wdata_in;
      end
      if (write_hit(reg_write_in, reg_addr_in, port_io_pkg::ADDR_INT_ENABLE)) begin
        keypad_int_enable <= reg_wdata_in[port_io_pkg::IEN_KEYPAD_BIT];
        global_int_enable <= reg_wdata_in[port_io_pkg::IEN_GLOBAL_BIT];
      end
    end
  end

  // ****************************************************************
  // keypad wake
  // ****************************************************************
  assign keypad_low = |(keypad_pin_enable_reg & ~pin_sync[7:0]);

  // a low key in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      keypad_wake_flag <= 1'b0;
    end else if (keypad_low) begin
      keypad_wake_flag <= 1'b1;
    end else if (write_hit(reg_write_in, reg_addr_in, port_io_pkg::ADDR_AUX_ONE)
                 && !reg_wdata_in[port_io_pkg::AUX_KBF_BIT]) begin
      keypad_wake_flag <= 1'b0;
    end
  end

  assign keypad_int_request_out = keypad_wake_flag && keypad_int_enable
                                  && global_int_enable;
  // wake ignores the global enable so sleep can end with interrupts masked
  assign keypad_wake_out = keypad_wake_flag && keypad_int_enable;

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        port_io_pkg::ADDR_PORT0:
          reg_rdata_out <= port_view(pin_sync[7:0], cell_disable[7:0]);
        port_io_pkg::ADDR_PORT1:
          reg_rdata_out <= port_view(pin_sync[15:8], cell_disable[15:8]);
        port_io_pkg::ADDR_PORT2:
          reg_rdata_out <= port_view(pin_sync[23:16], cell_disable[23:16]);
        port_io_pkg::ADDR_MODE_A0:    reg_rdata_out <= port_mode_select_a[0];
        port_io_pkg::ADDR_MODE_B0:    reg_rdata_out <= port_mode_select_b[0];
        port_io_pkg::ADDR_MODE_A1:    reg_rdata_out <= port_mode_select_a[1];
        port_io_pkg::ADDR_MODE_B1:    reg_rdata_out <= port_mode_select_b[1];
        port_io_pkg::ADDR_MODE_A2:    reg_rdata_out <= port_mode_select_a[2];
        port_io_pkg::ADDR_MODE_B2:    reg_rdata_out <= port_mode_select_b[2];
        port_io_pkg::ADDR_KEYPAD_EN:  reg_rdata_out <= keypad_pin_enable_reg;
        port_io_pkg::ADDR_AUX_ONE:    reg_rdata_out <= {6'h00, keypad_wake_flag, 1'b0};
        port_io_pkg::ADDR_INT_ENABLE:
          reg_rdata_out <= {6'h00, keypad_int_enable, global_int_enable};
        default:                      reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // pin cells
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      cell_mode[i]    = {port_mode_select_a[port_of(i)][bit_of(i)],
                         port_mode_select_b[port_of(i)][bit_of(i)]};
      cell_disable[i] = 1'b0;
    end
    cell_mode[8 + port_io_pkg::FIXED_OD_A_IDX] = port_io_pkg::MODE_OPEN;
    cell_mode[8 + port_io_pkg::FIXED_OD_B_IDX] = port_io_pkg::MODE_OPEN;
    // reset-shared pin never drives; it is only an input
    cell_mode[8 + port_io_pkg::RESET_PIN_IDX]  = port_io_pkg::MODE_INPUT;
    cell_disable[8 + port_io_pkg::RESET_PIN_IDX] = !internal_reset_in;
    cell_disable[16 + port_io_pkg::OSC_OUT_IDX]  = crystal_osc_in;
    cell_disable[16 + port_io_pkg::OSC_IN_IDX]   = crystal_osc_in;
  end

  for (genvar g = 0; g < 24; g++) begin : g_pin
    port_pin_cell u_cell (
      .sys_clk_in       (sys_clk_in),
      .rst_in           (rst_in),
      .mode_in          (cell_mode[g]),
      .latch_in         (port_latch[port_of(g)][bit_of(g)]),
      .pin_level_in     (pin_sync[g]),
      .disable_in       (cell_disable[g]),
      .very_weak_up_out (very_weak_up_out[g]),
      .weak_up_out      (weak_up_out[g]),
      .strong_up_out    (strong_up_out[g]),
      .pull_down_out    (pull_down_out[g])
    );
  end

  // ****************************************************************
  // port 2 spare enables and input thresholds
  // ****************************************************************
  always_comb begin
    schmitt_select_out[0] = port_mode_select_a[2][port_io_pkg::P2A_SCHMITT0_BIT];
    schmitt_select_out[1] = port_mode_select_a[2][port_io_pkg::P2A_SCHMITT1_BIT];
    schmitt_select_out[2] = port_mode_select_a[2][port_io_pkg::P2A_SCHMITT2_BIT];
    timer_toggle_enable_out[0] = port_mode_select_a[2][port_io_pkg::P2A_TOGGLE0_BIT];
    timer_toggle_enable_out[1] = port_mode_select_a[2][port_io_pkg::P2A_TOGGLE1_BIT];
    clock_out_enable_out = port_mode_select_a[2][port_io_pkg::P2A_CLKOUT_BIT] && !crystal_osc_in;
    fixed_pins_schmitt_out = 1'b1;
    reset_pin_schmitt_out  = internal_reset_in;
  end

  // reset_high holds the captured strap, but no register or output reads it
  logic unused_reset_high;
  assign unused_reset_high = reset_high;

endmodule

// ### dv/board_model.sv
// board side of the pins: keys to ground, board pull-ups, floating pins
// assumes one clock; a pin nobody drives flips each cycle instead of holding
`timescale 1ns/1ps
module board_model (
  input  wire logic        sys_clk_in,
  input  wire logic [23:0] up_in,
  input  wire logic [23:0] down_in,
  input  wire logic [23:0] key_low_in,
  input  wire logic [23:0] ext_pullup_in,
  output logic      [23:0] pin_level_out
);
  logic [23:0] last_level = 24'h00_0000;
  always @(posedge sys_clk_in) begin
    last_level <= pin_level_out;
  end
  // a pressed key or the pull-down wins; a floating pin never shows a stable value
  assign pin_level_out = ~(key_low_in | down_in) & (up_in | ext_pullup_in | ~last_level);
endmodule

// ### dv/port_io_keypad_asserts.sv
// checker on the ports of the i/o block
// assumes port 0 pin 0 stays quasi-bidirectional for the whole run
`timescale 1ns/1ps
module port_io_keypad_asserts (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        reg_write_in,
  input wire logic        internal_reset_in,
  input wire logic        crystal_osc_in,
  input wire logic [23:0] pin_level_in,
  input wire logic [23:0] very_weak_up_out,
  input wire logic [23:0] weak_up_out,
  input wire logic [23:0] strong_up_out,
  input wire logic [23:0] pull_down_out,
  input wire logic        reset_pin_schmitt_out,
  input wire logic        fixed_pins_schmitt_out,
  input wire logic        clock_out_enable_out,
  input wire logic        keypad_int_request_out,
  input wire logic        keypad_wake_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_no_contention: assert property (((very_weak_up_out | weak_up_out | strong_up_out)
    & pull_down_out) == 24'h00_0000) else $error("pull-up and pull-down on together");
  a_weak_needs_latch: assert property ((weak_up_out & ~very_weak_up_out) == 24'h00_0000)
    else $error("weak pull-up without very weak pull-up");
  a_weak_off_low: assert property ((~pin_level_in & $past(~pin_level_in)
    & $past(~pin_level_in, 2) & weak_up_out) == 24'h00_0000) else $error("weak on low pin");
  a_fixed_no_pull: assert property (((very_weak_up_out | weak_up_out | strong_up_out)
    & 24'h00_2C00) == 24'h00_0000) else $error("pull-up on fixed pin");
  a_schmitt_fixed: assert property (fixed_pins_schmitt_out
    && reset_pin_schmitt_out == internal_reset_in) else $error("schmitt select wrong");
  a_osc_pins_off: assert property (crystal_osc_in |-> !clock_out_enable_out
    && (very_weak_up_out[17:16] | weak_up_out[17:16] | strong_up_out[17:16]
    | pull_down_out[17:16]) == 2'b00) else $error("osc pin active");
  a_strong_two_clk: assert property ($rose(strong_up_out[0]) |=> strong_up_out[0]
    ##1 !strong_up_out[0]) else $error("strong pull-up burst not two clocks");
  a_int_gated: assert property (keypad_int_request_out |-> keypad_wake_out)
    else $error("keypad request without enabled flag");
  a_flag_sticky: assert property ($past(keypad_wake_out) && !$past(reg_write_in)
    |-> keypad_wake_out) else $error("keypad flag cleared by itself");
  a_flag_cause: assert property ($rose(keypad_wake_out) |-> $past(reg_write_in)
    || !(&$past(pin_level_in[7:0], 2)) || !(&$past(pin_level_in[7:0], 3)))
    else $error("keypad flag set with no low pin");
endmodule
bind port_io_keypad port_io_keypad_asserts u_chk (.sys_clk_in, .rst_in, .reg_write_in,
  .internal_reset_in, .crystal_osc_in, .pin_level_in, .very_weak_up_out, .weak_up_out,
  .strong_up_out, .pull_down_out, .reset_pin_schmitt_out, .fixed_pins_schmitt_out,
  .clock_out_enable_out, .keypad_int_request_out, .keypad_wake_out);

// ### dv/testbench.sv
// self-checking bench for the i/o block with keypad wake
// assumes the board model closes the pin loop; 10 MHz clock
`timescale 1ns/1ps
module testbench;
  logic sys_clk_in, rst_in, reg_write_in, reg_read_in, strap, int_rst, xtal;
  logic [3:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, d;
  logic [23:0] pins, vw, wk, st, pd, key_low;
  logic [2:0]  schm;
  logic [1:0]  tog;
  logic        clko, rst_schm, fix_schm, kint, kwake;
  logic [12:0] r;
  int          errors, samples_checked;
  // ****************************************************************
  // rows: mode a, mode b, latch, key, check mask, vw wk st pd, pin
  // ****************************************************************
  logic [12:0] rows [9] = '{13'b00_1_0_1111_1100_1, 13'b00_1_1_1111_1000_0,
    13'b00_0_0_1111_0001_0, 13'b01_1_0_0011_0010_1, 13'b01_0_0_0011_0001_0,
    13'b10_1_1_1111_0000_0, 13'b10_0_0_1111_0000_1, 13'b11_1_0_1111_0000_1,
    13'b11_0_0_1111_0001_0};
  port_io_keypad dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .pin_reset_high_select_in(strap),
    .internal_reset_in(int_rst), .crystal_osc_in(xtal), .pin_level_in(pins),
    .very_weak_up_out(vw), .weak_up_out(wk), .strong_up_out(st), .pull_down_out(pd),
    .schmitt_select_out(schm), .reset_pin_schmitt_out(rst_schm),
    .fixed_pins_schmitt_out(fix_schm), .timer_toggle_enable_out(tog),
    .clock_out_enable_out(clko), .keypad_int_request_out(kint), .keypad_wake_out(kwake));
  // board pull-ups on port 0 (keys) and on the two fixed open drain pins and pin 8
  board_model board (.sys_clk_in(sys_clk_in), .up_in(vw | wk | st), .down_in(pd),
    .key_low_in(key_low), .ext_pullup_in(24'h00_0DFF), .pin_level_out(pins));
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'b0;
    #1;
    v = reg_rdata_out;
  endtask
  task automatic do_reset(input logic hi);
    strap <= hi;
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    #1;
    check(pd, 24'hFF_DFFF & ~{6'h00, {2{xtal}}, 16'h0000});
    step(4);
    check(vw, 24'hFF_D3FF & {24{hi}});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst_in, reg_write_in, reg_read_in, xtal} = 4'h0;
    {strap, int_rst} = 2'b11;
    {reg_addr_in, reg_wdata_in, key_low} = 36'h0_0000_0000;
    errors = 0;
    samples_checked = 0;
    do_reset(1'b1);
    foreach (rows[i]) begin
      r = rows[i];
      wr_reg(port_io_pkg::ADDR_MODE_A1, {7'h00, r[12]});
      wr_reg(port_io_pkg::ADDR_MODE_B1, {7'h00, r[11]});
      wr_reg(port_io_pkg::ADDR_PORT1, {7'h7F, r[10]});
      key_low[8] <= r[9];
      step(4);
      check(24'({vw[8], wk[8], st[8], pd[8]} & r[8:5]), 24'(r[4:1]));
      rd_reg(port_io_pkg::ADDR_PORT1, d);
      check(24'(d[0]), 24'(r[0]));
    end
    // latch rise on a quasi pin: strong pull-up high for exactly two cycles
    wr_reg(port_io_pkg::ADDR_PORT0, 8'hFE);
    wr_reg(port_io_pkg::ADDR_PORT0, 8'hFF);
    #1;
    check(24'(st[0]), 24'h00_0001);
    step(1);
    check(24'(st[0]), 24'h00_0001);
    step(1);
    check(24'(st[0]), 24'h00_0000);
    // all of port 1 push-pull: the fixed pins ignore it
    wr_reg(port_io_pkg::ADDR_MODE_A1, 8'h00);
    wr_reg(port_io_pkg::ADDR_MODE_B1, 8'hFF);
    wr_reg(port_io_pkg::ADDR_PORT1, 8'hFF);
    step(1);
    check(24'(st[15:8]), 24'h00_00D3);
    wr_reg(port_io_pkg::ADDR_PORT1, 8'h00);
    step(1);
    check(24'(pd[15:8]), 24'h00_00DF);
    wr_reg(port_io_pkg::ADDR_MODE_A2, 8'hFC);
    step(1);
    check(24'({schm, tog, clko, fix_schm, rst_schm}), 24'h00_00FF);
    int_rst <= 1'b0;
    xtal <= 1'b1;
    step(2);
    check(24'({clko, rst_schm, vw[17:16], pd[17:16]}), 24'h00_0000);
    rd_reg(port_io_pkg::ADDR_PORT2, d);
    check(24'(d[1:0]), 24'h00_0000);
    rd_reg(port_io_pkg::ADDR_PORT1, d);
    check(24'(d[5]), 24'h00_0000);
    rd_reg(4'hF, d);
    check(24'(d), 24'h00_0000);
    // keypad: only pin 3 enabled, global enable off at first
    key_low <= 24'h00_0004;
    wr_reg(port_io_pkg::ADDR_KEYPAD_EN, 8'h08);
    wr_reg(port_io_pkg::ADDR_INT_ENABLE, 8'h02);
    step(4);
    check(24'(kwake), 24'h00_0000);
    key_low <= 24'h00_0008;
    step(4);
    check(24'({kwake, kint}), 24'h00_0002);
    wr_reg(port_io_pkg::ADDR_INT_ENABLE, 8'h03);
    step(1);
    check(24'({kwake, kint}), 24'h00_0003);
    key_low <= 24'h00_0000;
    step(6);
    check(24'(kwake), 24'h00_0001);
    rd_reg(port_io_pkg::ADDR_AUX_ONE, d);
    check(24'(d[1]), 24'h00_0001);
    key_low <= 24'h00_0008;
    step(4);
    wr_reg(port_io_pkg::ADDR_AUX_ONE, 8'h00);
    step(1);
    check(24'(kwake), 24'h00_0001);
    key_low <= 24'h00_0000;
    step(4);
    wr_reg(port_io_pkg::ADDR_AUX_ONE, 8'h00);
    step(1);
    check(24'(kwake), 24'h00_0000);
    do_reset(1'b0);
    print_verdict();
  end
endmodule
